// >>> hdl/input_capture_pkg.sv
// constants and carrier types for input capture and routing
package input_capture_pkg;

    // object addressing
    localparam logic [15:0] CAPTURE_INDEX = 16'h3241;
    localparam logic [15:0] ROUTE_INDEX = 16'h3242;
    localparam logic [7:0] SUB_ENTRY_COUNT = 8'h00;
    localparam logic [7:0] SUB_EDGE_SELECT = 8'h01;
    localparam logic [7:0] SUB_EVENT_COUNT = 8'h02;
    localparam logic [7:0] SUB_USER_POS = 8'h03;
    localparam logic [7:0] SUB_RAW_POS = 8'h04;
    localparam logic [7:0] ROUTE_SUB_FIRST = 8'h01;

    // entry counts and reset values
    localparam logic [7:0] CAPTURE_ENTRIES = 8'h04;
    localparam logic [7:0] ROUTE_ENTRIES = 8'h24;
    localparam int ROUTE_COUNT = 36;
    localparam logic [31:0] CAPTURE_RESET = 32'h0000_0000;
    localparam logic [7:0] ROUTE_RESET = 8'h00;

    // edge selection codes
    localparam logic [31:0] EDGE_OFF = 32'h0000_0000;
    localparam logic [31:0] EDGE_RISE = 32'h0000_0001;
    localparam logic [31:0] EDGE_FALL = 32'h0000_0002;
    localparam logic [31:0] EDGE_BOTH = 32'h0000_0003;

    // digital input 2 sits at bit 1 of the physical inputs
    localparam int CAPTURE_INPUT_BIT = 1;
    localparam logic [31:0] ROUTING_ON = 32'h0000_0001;

    // routing source codes, bit 7 selects the inverted form
    localparam logic [6:0] SRC_CONST = 7'h00;
    localparam logic [6:0] SRC_PHYS_FIRST = 7'h01;
    localparam logic [6:0] SRC_PHYS_LAST = 7'h10;
    localparam logic [6:0] SRC_ENC_A = 7'h44;
    localparam logic [6:0] SRC_ENC_B = 7'h45;
    localparam logic [6:0] SRC_ENC_INDEX = 7'h46;
    localparam logic [6:0] SRC_USB_POWER = 7'h47;
    localparam logic [6:0] SRC_DIP_FIRST = 7'h49;
    localparam logic [6:0] SRC_DIP_LAST = 7'h50;
    localparam int SRC_INVERT_BIT = 7;

    // every external level that the router can pick
    typedef struct packed {
        logic [15:0] phys;
        logic enc_a;
        logic enc_b;
        logic enc_index;
        logic usb_power;
        logic [7:0] dip;
    } input_sources_t;

    // one object access request
    typedef struct packed {
        logic req;
        logic write;
        logic [15:0] index;
        logic [7:0] subindex;
        logic [31:0] wdata;
    } od_request_t;

endpackage : input_capture_pkg

// >>> hdl/source_selector.sv
// picks one routed bit from the source set by its code
`timescale 1ns/1ps
module source_selector
    import input_capture_pkg::*;
(
    // selection
    input wire logic [7:0] code,
    input wire input_sources_t src,
    // result
    output logic bit_out
);

    always_comb begin
        logic [6:0] base;
        logic inv;
        logic valid;
        logic v;
        base = code[6:0];
        inv = code[SRC_INVERT_BIT];
        valid = 1'b1;
        v = 1'b0;
        // constant 0, and its inverse constant 1
        if (base == SRC_CONST) begin
            v = 1'b0; // R10
        end else if (base >= SRC_PHYS_FIRST && base <= SRC_PHYS_LAST) begin
            v = src.phys[4'(base - SRC_PHYS_FIRST)]; // R11 R13
        end else if (base == SRC_ENC_A) begin
            v = src.enc_a; // R12 R14
        end else if (base == SRC_ENC_B) begin
            v = src.enc_b; // R12 R14
        end else if (base == SRC_ENC_INDEX) begin
            v = src.enc_index; // R12 R14
        end else if (base == SRC_USB_POWER) begin
            v = src.usb_power; // R12 R14
        end else if (!inv && base >= SRC_DIP_FIRST &&
                     base <= SRC_DIP_LAST) begin
            // dip switches have no inverted form
            v = src.dip[3'(base - SRC_DIP_FIRST)]; // R11
        end else begin
            valid = 1'b0;
        end
        bit_out = valid ? (v ^ inv) : 1'b0; // R16
    end

endmodule : source_selector

// >>> hdl/input_capture_and_routing.sv
// position capture on digital input 2 and input status routing
//
// Operation
// R1 - watch digital input 2; on a selected edge record encoder position
// R2 - edge select: 0 off, 1 rising, 2 falling, 3 both edges
// R3 - event counter counts captured edges since capturing started
// R4 - writing 1, 2 or 3 to edge select clears the event counter
// R5 - each capture stores the actual position in user units
// R6 - each capture stores the raw sensor position separately
// R7 - capture object reports 4 entries; all its fields reset to zero
// R8 - routing entry n drives bit n-1 of the input status word
// R9 - 36 writable 8-bit selectors, highest entry 24h, reset to 00h
// R10 - code 00h gives constant 0, code 80h gives constant 1
// R11 - 01h-10h pick physical inputs 1-16; 49h-50h pick dip switches 1-8
// R12 - 44h, 45h, 46h pick encoder A, B, index; 47h picks usb power
// R13 - 81h-90h pick inverted physical inputs 1-16
// R14 - C4h-C6h pick inverted encoder A, B, index; C7h inverted usb power
// R15 - selectors govern the status word only while routing enable is 1
// R16 - any unassigned source code yields constant 0
// R17 - capture input is synchronised; edges come from consecutive samples
`timescale 1ns/1ps
module input_capture_and_routing
    import input_capture_pkg::*;
#(
    parameter int NUM_ROUTES = ROUTE_COUNT
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // object access port
    input wire od_request_t od_request,
    output logic od_ack,
    output logic od_error,
    output logic [31:0] od_rdata,
    // pins
    input wire logic [15:0] phys_in,
    input wire logic enc_a_in,
    input wire logic enc_b_in,
    input wire logic enc_index_in,
    input wire logic usb_power_in,
    input wire logic [7:0] dip_switch_in,
    // position sources, same clock
    input wire logic [31:0] actual_position_user_units,
    input wire logic [31:0] raw_sensor_position,
    // routing control from the input control logic
    input wire logic [31:0] routing_enable,
    input wire logic [NUM_ROUTES-1:0] default_status_word,
    // results
    output logic [NUM_ROUTES-1:0] digital_input_status_word,
    output logic capture_strobe
);

    localparam int SRC_W = $bits(input_sources_t);
    localparam int SLOT_W = $clog2(NUM_ROUTES);

    function automatic logic route_hit(input logic [15:0] idx,
                                       input logic [7:0] sub);
        route_hit = idx == ROUTE_INDEX && sub >= ROUTE_SUB_FIRST &&
                    sub <= 8'(NUM_ROUTES);
    endfunction : route_hit

    function automatic logic capture_hit(input logic [15:0] idx,
                                         input logic [7:0] sub);
        capture_hit = idx == CAPTURE_INDEX && sub <= CAPTURE_ENTRIES;
    endfunction : capture_hit

    function automatic logic starts_capture(input logic [31:0] mode);
        starts_capture = mode == EDGE_RISE || mode == EDGE_FALL ||
                         mode == EDGE_BOTH;
    endfunction : starts_capture

    // pin synchroniser, first stage read by the second only
    logic [SRC_W-1:0] sync1_q;
    logic [SRC_W-1:0] sync2_q;
    logic [SRC_W-1:0] sync3_q;
    logic [SRC_W-1:0] filt_q;
    input_sources_t pins;
    input_sources_t src;

    always_comb begin
        pins.phys = phys_in;
        pins.enc_a = enc_a_in;
        pins.enc_b = enc_b_in;
        pins.enc_index = enc_index_in;
        pins.usb_power = usb_power_in;
        pins.dip = dip_switch_in;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // a level counts only once stages two and three agree
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            filt_q <= '0;
        end else begin
            filt_q <= (~(sync2_q ^ sync3_q) & sync3_q) |
                      ((sync2_q ^ sync3_q) & filt_q); // R17
        end
    end

    assign src = input_sources_t'(filt_q);

    // edge detection on digital input 2
    logic cap_prev_q;
    logic cap_now;
    logic rise;
    logic fall;
    logic edge_hit;

    assign cap_now = src.phys[CAPTURE_INPUT_BIT]; // R1

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_prev_q <= 1'b0;
        end else begin
            cap_prev_q <= cap_now; // R17
        end
    end

    assign rise = cap_now & ~cap_prev_q; // R17
    assign fall = ~cap_now & cap_prev_q; // R17

    // capture registers
    logic [31:0] edge_select_q;
    logic [31:0] event_count_q;
    logic [31:0] event_count_d;
    logic [31:0] user_pos_q;
    logic [31:0] raw_pos_q;

    always_comb begin
        unique case (edge_select_q)
            EDGE_RISE: edge_hit = rise; // R2
            EDGE_FALL: edge_hit = fall; // R2
            EDGE_BOTH: edge_hit = rise | fall; // R2
            default: edge_hit = 1'b0; // R2
        endcase
    end

    // access decode
    logic wr;
    logic cap_wr;
    logic sel_wr;
    logic cnt_wr;
    logic upos_wr;
    logic rpos_wr;
    logic start_wr;

    assign wr = od_request.req & od_request.write;
    assign cap_wr = wr && od_request.index == CAPTURE_INDEX;
    assign sel_wr = cap_wr && od_request.subindex == SUB_EDGE_SELECT;
    assign cnt_wr = cap_wr && od_request.subindex == SUB_EVENT_COUNT;
    assign upos_wr = cap_wr && od_request.subindex == SUB_USER_POS;
    assign rpos_wr = cap_wr && od_request.subindex == SUB_RAW_POS;
    // only a real start code clears; writing off keeps the count
    assign start_wr = sel_wr && starts_capture(od_request.wdata); // R4

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_select_q <= CAPTURE_RESET; // R7
        end else if (sel_wr) begin
            edge_select_q <= od_request.wdata; // R2
        end
    end

    // a capture in the clearing cycle still counts, set beats clear
    always_comb begin
        event_count_d = event_count_q;
        if (start_wr) begin
            event_count_d = CAPTURE_RESET; // R4
        end else if (cnt_wr) begin
            event_count_d = od_request.wdata;
        end
        if (edge_hit) begin
            event_count_d = event_count_d + 32'h0000_0001; // R3
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            event_count_q <= CAPTURE_RESET; // R7
        end else begin
            event_count_q <= event_count_d;
        end
    end

    // a capture beats a software write in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            user_pos_q <= CAPTURE_RESET; // R7
        end else if (edge_hit) begin
            user_pos_q <= actual_position_user_units; // R5 R1
        end else if (upos_wr) begin
            user_pos_q <= od_request.wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            raw_pos_q <= CAPTURE_RESET; // R7
        end else if (edge_hit) begin
            raw_pos_q <= raw_sensor_position; // R6
        end else if (rpos_wr) begin
            raw_pos_q <= od_request.wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            capture_strobe <= 1'b0;
        end else begin
            capture_strobe <= edge_hit;
        end
    end

    // routing selectors
    logic [7:0] route_sel_q [NUM_ROUTES];
    logic [SLOT_W-1:0] slot;
    logic [NUM_ROUTES-1:0] routed;
    logic [NUM_ROUTES-1:0] status_d;

    assign slot = SLOT_W'(od_request.subindex - ROUTE_SUB_FIRST); // R8

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_ROUTES; i++) begin
                route_sel_q[i] <= ROUTE_RESET; // R9
            end
        end else if (wr && route_hit(od_request.index, od_request.subindex))
        begin
            route_sel_q[slot] <= od_request.wdata[7:0]; // R9
        end
    end

    // one selector per status bit
    generate
        for (genvar n = 0; n < NUM_ROUTES; n++) begin : g_route
            source_selector u_sel (
                .code(route_sel_q[n]),
                .src(src),
                .bit_out(routed[n])
            ); // R8
        end
    endgenerate

    // routing only takes over on the exact enable value
    always_comb begin
        status_d = default_status_word; // R15
        if (routing_enable == ROUTING_ON) begin
            status_d = routed; // R15
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            digital_input_status_word <= '0;
        end else begin
            digital_input_status_word <= status_d;
        end
    end

    // object access answer, one cycle after the request
    logic known;
    logic ro_wr;
    logic refused;
    logic rd_req;
    logic [31:0] cap_rdata;
    logic [31:0] route_rdata;
    logic [31:0] rdata_d;

    assign known = capture_hit(od_request.index, od_request.subindex) ||
                   route_hit(od_request.index, od_request.subindex) ||
                   (od_request.index == ROUTE_INDEX &&
                    od_request.subindex == SUB_ENTRY_COUNT);
    assign ro_wr = od_request.write &&
                   od_request.subindex == SUB_ENTRY_COUNT;
    assign refused = !known || ro_wr;
    assign rd_req = od_request.req && !od_request.write;

    always_comb begin
        unique case (od_request.subindex)
            SUB_ENTRY_COUNT: cap_rdata = 32'(CAPTURE_ENTRIES); // R7
            SUB_EDGE_SELECT: cap_rdata = edge_select_q; // R2
            SUB_EVENT_COUNT: cap_rdata = event_count_q; // R3
            SUB_USER_POS: cap_rdata = user_pos_q; // R5
            SUB_RAW_POS: cap_rdata = raw_pos_q; // R6
            default: cap_rdata = 32'h0000_0000;
        endcase
    end

    // selectors read back zero-extended to the word
    always_comb begin
        route_rdata = 32'h0000_0000;
        if (od_request.subindex == SUB_ENTRY_COUNT) begin
            route_rdata = 32'(ROUTE_ENTRIES); // R9
        end else if (route_hit(od_request.index, od_request.subindex)) begin
            route_rdata = {24'h00_0000, route_sel_q[slot]}; // R9
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (od_request.index == CAPTURE_INDEX) begin
            rdata_d = cap_rdata;
        end else if (od_request.index == ROUTE_INDEX) begin
            rdata_d = route_rdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            od_ack <= 1'b0;
        end else begin
            od_ack <= od_request.req;
        end
    end

    // refused accesses change no state, they only answer with an error
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            od_error <= 1'b0;
        end else begin
            od_error <= od_request.req && refused; // R7 R9
        end
    end

    // read data holds between reads so it can be picked up late
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            od_rdata <= 32'h0000_0000;
        end else if (rd_req) begin
            od_rdata <= rdata_d;
        end
    end

endmodule : input_capture_and_routing

// >>> dv/input_capture_monitor.sv
// assertion checker on the capture and routing ports
`timescale 1ns/1ps
module input_capture_monitor
    import input_capture_pkg::*;
#(
    parameter int NUM_ROUTES = ROUTE_COUNT
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // object access
    input wire od_request_t od_request,
    input wire logic od_ack,
    input wire logic od_error,
    input wire logic [31:0] od_rdata,
    // status word
    input wire logic [31:0] routing_enable,
    input wire logic [NUM_ROUTES-1:0] default_status_word,
    input wire logic [NUM_ROUTES-1:0] digital_input_status_word
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic rq;
    logic rdq;
    logic [15:0] idx;
    logic [7:0] sub;
    assign rq = od_request.req;
    assign rdq = rq && !od_request.write;
    assign idx = od_request.index;
    assign sub = od_request.subindex;

    property p_ack; rq |=> od_ack; endproperty
    a_ack: assert property (p_ack)
        else $error("no ack after request");
    property p_ro; rq && od_request.write && sub == 8'h00 &&
        (idx == CAPTURE_INDEX || idx == ROUTE_INDEX) |=> od_error;
    endproperty
    a_ro: assert property (p_ro)
        else $error("entry count write accepted");
    property p_cap_n; rdq && idx == CAPTURE_INDEX && sub == 8'h00
        |=> od_rdata == 32'h4 && !od_error; endproperty
    a_cap_n: assert property (p_cap_n)
        else $error("capture entry count wrong");
    property p_rt_n; rdq && idx == ROUTE_INDEX && sub == 8'h00
        |=> od_rdata == 32'h24 && !od_error; endproperty
    a_rt_n: assert property (p_rt_n)
        else $error("route entry count wrong");
    property p_rt_range; rq && idx == ROUTE_INDEX && sub > 8'h24
        |=> od_ack && od_error; endproperty
    a_rt_range: assert property (p_rt_range)
        else $error("route subindex above range accepted");
    property p_cap_range; rq && idx == CAPTURE_INDEX && sub > 8'h04
        |=> od_error; endproperty
    a_cap_range: assert property (p_cap_range)
        else $error("capture subindex above range accepted");
    property p_sel_wr; rq && od_request.write && idx == ROUTE_INDEX &&
        sub inside {[8'h01:8'h24]} |=> od_ack && !od_error; endproperty
    a_sel_wr: assert property (p_sel_wr)
        else $error("selector write refused");
    property p_sel_w; rdq && idx == ROUTE_INDEX && sub != 8'h00
        |=> od_rdata[31:8] == 24'h0; endproperty
    a_sel_w: assert property (p_sel_w)
        else $error("selector wider than 8 bits");
    property p_hold; !rdq |=> $stable(od_rdata); endproperty
    a_hold: assert property (p_hold)
        else $error("read data moved without a read");
    property p_dflt; (routing_enable != 32'h1 &&
        $stable(default_status_word))[*3]
        |=> digital_input_status_word == default_status_word; endproperty
    a_dflt: assert property (p_dflt)
        else $error("default mapping not applied");
endmodule : input_capture_monitor

bind input_capture_and_routing input_capture_monitor #(
    .NUM_ROUTES(NUM_ROUTES)
) mon (
    .ref_clk(ref_clk), .rst_n(rst_n), .od_request(od_request),
    .od_ack(od_ack), .od_error(od_error), .od_rdata(od_rdata),
    .routing_enable(routing_enable),
    .default_status_word(default_status_word),
    .digital_input_status_word(digital_input_status_word)
);

// >>> dv/pin_model.sv
// pin, encoder and switch levels facing the device
`timescale 1ns/1ps
module pin_model (
    // levels seen by the device
    output logic [15:0] phys_in,
    output logic enc_a,
    output logic enc_b,
    output logic enc_index,
    output logic usb_power,
    output logic [7:0] dip
);
    initial {phys_in, enc_a, enc_b, enc_index, usb_power, dip} = '0;
    // pins are asynchronous, so any time is legal
    task automatic set_all(input logic [27:0] v);
        {phys_in, enc_a, enc_b, enc_index, usb_power, dip} = v;
    endtask : set_all
    task automatic set_in2(input logic lvl);
        phys_in[1] = lvl;
    endtask : set_in2
endmodule : pin_model

// >>> dv/test_input_capture_and_routing.sv
// testbench for input capture and routing
`timescale 1ns/1ps
module test_input_capture_and_routing;
    import input_capture_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    od_request_t od_request = '0;
    logic od_ack, od_error, capture_strobe;
    logic [31:0] od_rdata, user_pos = '0, raw_pos = '0, route_en = '0;
    logic [35:0] dflt = 36'h9_1234_5678, status;
    logic [15:0] phys;
    logic enc_a, enc_b, enc_i, usb;
    logic [7:0] dip;
    int failures = 0, check_count = 0;
    logic [27:0] pat [2] = '{28'hA5C3_A6A, 28'h5A3C_596};
    logic [31:0] modes [4] = '{32'h1, 32'h2, 32'h3, 32'h0};
    logic [7:0] codes [18] = '{8'h00, 8'h80, 8'h01, 8'h10, 8'h44, 8'h45,
        8'h46, 8'h47, 8'h49, 8'h50, 8'h81, 8'h90, 8'hC4, 8'hC5, 8'hC6,
        8'hC7, 8'h48, 8'hC9};
    always #10 ref_clk = ~ref_clk;

    pin_model pins (.phys_in(phys), .enc_a(enc_a), .enc_b(enc_b),
        .enc_index(enc_i), .usb_power(usb), .dip(dip));
    input_capture_and_routing #(.NUM_ROUTES(36)) DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .od_request(od_request),
        .od_ack(od_ack), .od_error(od_error), .od_rdata(od_rdata),
        .phys_in(phys), .enc_a_in(enc_a), .enc_b_in(enc_b),
        .enc_index_in(enc_i), .usb_power_in(usb), .dip_switch_in(dip),
        .actual_position_user_units(user_pos),
        .raw_sensor_position(raw_pos), .routing_enable(route_en),
        .default_status_word(dflt), .digital_input_status_word(status),
        .capture_strobe(capture_strobe));

    task automatic chk(input string what, input logic [35:0] seen, ev);
        check_count++;
        if (seen !== ev) begin
            failures++;
            $display("BAD %s exp %h seen %h", what, ev, seen);
        end
    endtask : chk
    task automatic access(input logic w, input logic [15:0] idx,
        input logic [7:0] sub, input logic [31:0] wd, input logic err,
        output logic [31:0] d);
        @(posedge ref_clk);
        #1 od_request = {1'b1, w, idx, sub, wd};
        @(posedge ref_clk);
        #1 od_request.req = 1'b0;
        chk("ack", {35'h0, od_ack}, 36'h1);
        chk("error", {35'h0, od_error}, {35'h0, err});
        d = od_rdata;
    endtask : access
    task automatic wr(input logic [15:0] idx, input logic [7:0] sub,
        input logic [31:0] wd, input logic err);
        logic [31:0] d;
        access(1'b1, idx, sub, wd, err, d);
    endtask : wr
    task automatic rd(input logic [15:0] idx, input logic [7:0] sub,
        input logic [31:0] ev, input logic err);
        logic [31:0] d;
        access(1'b0, idx, sub, 32'h0, err, d);
        chk("rdata", {4'h0, d}, {4'h0, ev});
    endtask : rd
    // strobes are counted over a window longer than the pin latency
    task automatic pin2(input logic lvl, input logic hit);
        logic [3:0] n;
        n = 4'h0;
        @(posedge ref_clk);
        #1 pins.set_in2(lvl);
        repeat (12) begin
            @(posedge ref_clk);
            #1 n = n + {3'h0, capture_strobe};
        end
        chk("strobes", {32'h0, n}, {35'h0, hit});
    endtask : pin2
    function automatic logic src_bit(input logic [7:0] c,
        input logic [27:0] p);
        if (c == 8'h80) return 1'b1;
        if (c inside {[8'h01:8'h10]}) return p[c + 8'h0B];
        if (c inside {[8'h81:8'h90]}) return !p[c - 8'h75];
        if (c inside {[8'h44:8'h47]}) return p[8'h4F - c];
        if (c inside {[8'hC4:8'hC7]}) return !p[8'hCF - c];
        if (c inside {[8'h49:8'h50]}) return p[c - 8'h49];
        return 1'b0;
    endfunction : src_bit
    task automatic close_out;
        if (failures == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out

    initial begin
        logic [35:0] ev;
        logic [31:0] cnt, eu, er;
        cnt = 32'h0;
        eu = 32'h0;
        er = 32'h0;
        repeat (2) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        for (int s = 0; s < 5; s++) begin
            rd(CAPTURE_INDEX, 8'(s), s == 0 ? 32'h4 : 32'h0, 1'b0);
        end
        rd(CAPTURE_INDEX, 8'h05, 32'h0, 1'b1);
        wr(CAPTURE_INDEX, 8'h00, 32'h9, 1'b1);
        rd(CAPTURE_INDEX, 8'h00, 32'h4, 1'b0);
        rd(ROUTE_INDEX, 8'h00, 32'h24, 1'b0);
        rd(ROUTE_INDEX, 8'h24, 32'h0, 1'b0);
        wr(ROUTE_INDEX, 8'h25, 32'h1, 1'b1);
        wr(ROUTE_INDEX, 8'h00, 32'h1, 1'b1);
        wr(ROUTE_INDEX, 8'h24, 32'h180, 1'b0);
        rd(ROUTE_INDEX, 8'h24, 32'h80, 1'b0);
        for (int i = 0; i < 18; i++) begin
            wr(ROUTE_INDEX, 8'(i + 1), {24'h0, codes[i]}, 1'b0);
        end
        rd(ROUTE_INDEX, 8'h0D, 32'hC4, 1'b0);
        route_en = 32'h1;
        foreach (pat[k]) begin
            pins.set_all(pat[k]);
            ev = 36'h8_0000_0000;
            for (int i = 0; i < 18; i++) ev[i] = src_bit(codes[i], pat[k]);
            repeat (8) @(posedge ref_clk);
            #1 chk("routed", status, ev);
        end
        route_en = 32'h2;
        repeat (4) @(posedge ref_clk);
        #1 chk("default", status, dflt);
        wr(CAPTURE_INDEX, SUB_EVENT_COUNT, 32'h7, 1'b0);
        rd(CAPTURE_INDEX, SUB_EVENT_COUNT, 32'h7, 1'b0);
        wr(CAPTURE_INDEX, SUB_USER_POS, 32'h5A, 1'b0);
        rd(CAPTURE_INDEX, SUB_USER_POS, 32'h5A, 1'b0);
        // mode bit 0 arms rising, bit 1 falling
        foreach (modes[m]) begin
            wr(CAPTURE_INDEX, SUB_EDGE_SELECT, modes[m], 1'b0);
            rd(CAPTURE_INDEX, SUB_EDGE_SELECT, modes[m], 1'b0);
            if (modes[m] != 32'h0) cnt = 32'h0;
            rd(CAPTURE_INDEX, SUB_EVENT_COUNT, cnt, 1'b0);
            for (int e = 0; e < 2; e++) begin
                user_pos = user_pos + 32'h11;
                raw_pos = raw_pos + 32'h3;
                pin2(e == 0, modes[m][e]);
                if (modes[m][e]) begin
                    cnt = cnt + 32'h1;
                    eu = user_pos;
                    er = raw_pos;
                end
            end
            rd(CAPTURE_INDEX, SUB_EVENT_COUNT, cnt, 1'b0);
            rd(CAPTURE_INDEX, SUB_USER_POS, eu, 1'b0);
            rd(CAPTURE_INDEX, SUB_RAW_POS, er, 1'b0);
        end
        close_out();
    end
endmodule : test_input_capture_and_routing
